// ===== pkg/mbsre_pkg.sv
package mbsre_pkg;

   // ==========================================================
   // function codes and exceptions
   localparam logic [7:0] FC_READ_COILS   = 8'h01;
   localparam logic [7:0] FC_READ_INPUTS  = 8'h02;
   localparam logic [7:0] FC_READ_HOLD    = 8'h03;
   localparam logic [7:0] FC_READ_INPUT   = 8'h04;
   localparam logic [7:0] FC_WRITE_COIL   = 8'h05;
   localparam logic [7:0] EXC_FLAG        = 8'h80;
   localparam logic [7:0] EXC_ILL_FUNC    = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR    = 8'h02;
   localparam logic [7:0] EXC_ILL_DATA    = 8'h03;
   localparam logic [7:0] EXC_DEV_FAIL    = 8'h04;

   // ==========================================================
   // addressing, coil values, tcp settings and frame sizes
   localparam logic [7:0]  ADDR_BROADCAST = 8'h00;
   localparam logic [7:0]  ADDR_MIN       = 8'h01;
   localparam logic [7:0]  ADDR_MAX       = 8'h7F;
   localparam logic [15:0] COIL_ON        = 16'hFF00;
   localparam logic [15:0] COIL_OFF       = 16'h0000;
   localparam logic [15:0] TCP_PORT       = 16'h01F6;
   localparam logic [15:0] PROTO_ID       = 16'h0000;
   localparam int          MAX_TCP_CONN   = 3;
   localparam int          SER_HDR_BYTES  = 2;
   localparam int          TCP_HDR_BYTES  = 8;
   localparam int          CRC_BYTES      = 2;

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [15:0] RST_WORD       = 16'h0000;

   // ==========================================================
   // stream carriers
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } mbsre_byte_t;

   typedef struct packed {
      logic [15:0] start;
      logic [15:0] qty;
   } mbsre_req_t;

endpackage

// ===== logic/mbsre_fifo.sv
`timescale 1ns/1ns
module mbsre_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wrPtr;
   logic [AW-1:0]    next_rdPtr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign inReady  = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_comb begin
      next_wrPtr = push ? bump(wrPtr) : wrPtr;
      next_rdPtr = pop ? bump(rdPtr) : rdPtr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (reset)
      count <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule

// ===== logic/mbsre_crc.sv
`timescale 1ns/1ns
module mbsre_crc (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        clear,
   input  wire logic        enable,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc
);
   // standard reflected crc-16 with polynomial 0xA001, seed all ones
   logic [15:0] next_crc;

   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
      end
      crcByte = r;
   endfunction

   always_comb begin
      next_crc = crc;
      if (clear) begin
         next_crc = 16'hFFFF;
      end else if (enable) begin
         next_crc = crcByte(crc, data);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         crc <= 16'hFFFF;
      end else begin
         crc <= next_crc;
      end
   end
endmodule

// ===== logic/mbsre_engine.sv
`timescale 1ns/1ns
// Functional notes
// - serial: answer only own id 1..127
// - ignore broadcast 0 and ids 128..247
// - tcp: unit id not checked, echoed
// - tcp header: transaction, protocol, length, unit
// - tcp port 502, same register map
// - at most three tcp connections
// - codes 1..5 only, else illegal function
// - serial crc checked and appended; tcp none
// - serial framing options configured outside
// - codes 1 and 2 answer identically
// - zero-based start, two-byte quantity
// - coil bits packed lsb first, zero pad
// - byte count is quantity over eight, rounded up
// - bit one means logically active
// - exception: code plus 0x80, one byte
// - codes 3 and 4 alike, count twice quantity
// - float lower half in first register
// - register sent high byte first
// - 0xFF00 on, 0x0000 off, else unchanged
// - force echoes request after write
// - no force while in service mode
module mbsre_engine #(
   parameter int NCOILS = 18,
   parameter int NREGS  = 117,
   parameter int NACT   = 18,
   parameter int DEPTH  = 8
) (
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire logic                     tcpMode,
   input  wire logic [7:0]               slaveId,
   input  wire logic [1:0]               tcpConnCount,
   input  wire logic                     serviceMode,
   input  wire logic                     rxValid,
   input  wire mbsre_pkg::mbsre_byte_t   rxByte,
   input  wire logic                     rxCrcOk,
   input  wire logic [NCOILS-1:0]        coilStatus,
   output logic      [$clog2(NREGS)-1:0] regIndex,
   input  wire logic [31:0]              regFloat,
   output logic      [NACT-1:0]          actionCoil,
   output logic                          txValid,
   input  wire logic                     txReady,
   output mbsre_pkg::mbsre_byte_t        txByte,
   output logic                          acceptConn
);
   localparam int RW = $clog2(NREGS);

   typedef enum logic [2:0] {
      MBSRE_IDLE = 3'b000, MBSRE_RECV = 3'b001, MBSRE_EXEC = 3'b011,
      MBSRE_SEND = 3'b010, MBSRE_DROP = 3'b110
   } mbsre_state_t;

   // ==========================================================
   // state
   mbsre_state_t        state, next_state;
   logic [7:0]          hdr [8];
   logic [7:0]          next_hdr [8];
   logic [3:0]          rxCnt, next_rxCnt;
   logic [7:0]          func, next_func;
   logic [7:0]          pdu [4];
   logic [7:0]          next_pdu [4];
   logic [7:0]          exc, next_exc;
   logic [8:0]          txIdx, next_txIdx;
   logic [8:0]          txLen, next_txLen;
   logic [NACT-1:0]     next_actionCoil;
   logic                crcClear;
   logic                crcEn;
   logic [15:0]         crc;
   logic                fifoInValid;
   logic                fifoInReady;
   mbsre_pkg::mbsre_byte_t fifoIn;
   logic [7:0]          outB;
   logic [15:0]         start, qty, value;
   logic [16:0]         reach;
   logic [8:0]          dataLen;
   logic [3:0]          hdrLen;

   assign start   = {pdu[0], pdu[1]};
   assign qty     = {pdu[2], pdu[3]};
   assign value   = qty;
   assign reach   = {1'b0, start} + {1'b0, qty};
   assign hdrLen  = tcpMode ? 4'(mbsre_pkg::TCP_HDR_BYTES) : 4'(mbsre_pkg::SER_HDR_BYTES);
   assign acceptConn = tcpConnCount < 2'(mbsre_pkg::MAX_TCP_CONN);

   function automatic logic isRead1(input logic [7:0] f);
      isRead1 = (f == mbsre_pkg::FC_READ_COILS) || (f == mbsre_pkg::FC_READ_INPUTS);
   endfunction
   function automatic logic isRead3(input logic [7:0] f);
      isRead3 = (f == mbsre_pkg::FC_READ_HOLD) || (f == mbsre_pkg::FC_READ_INPUT);
   endfunction
   function automatic logic idOk(input logic [7:0] a);
      idOk = (a == slaveId) && (a >= mbsre_pkg::ADDR_MIN) && (a <= mbsre_pkg::ADDR_MAX);
   endfunction

   // ==========================================================
   // receive, validate, execute
   always_comb begin
      next_state      = state;
      next_hdr        = hdr;
      next_rxCnt      = rxCnt;
      next_func       = func;
      next_pdu        = pdu;
      next_exc        = exc;
      next_txLen      = txLen;
      next_actionCoil = actionCoil;
      dataLen         = '0;
      case (state)
         MBSRE_IDLE, MBSRE_RECV: begin
            if (rxValid) begin
               next_state = rxByte.last ? MBSRE_EXEC : MBSRE_RECV;
               if (rxCnt < hdrLen - 4'd1) begin
                  next_hdr[3'(rxCnt)] = rxByte.data;
               end else if (rxCnt == hdrLen - 4'd1) begin
                  next_func = rxByte.data;
               end else if (rxCnt < hdrLen + 4'd4) begin
                  next_pdu[2'(rxCnt - hdrLen)] = rxByte.data;
               end
               if (rxCnt != 4'hF) begin
                  next_rxCnt = rxCnt + 4'd1;
               end
            end
         end
         MBSRE_EXEC: begin
            next_rxCnt = '0;
            next_exc   = '0;
            next_state = MBSRE_SEND;
            // serial frame addressed elsewhere or with a bad check: drop silently
            if (!tcpMode && (!idOk(hdr[0]) || !rxCrcOk)) begin
               next_state = MBSRE_DROP;
            end else if (tcpMode && {hdr[2], hdr[3]} != mbsre_pkg::PROTO_ID) begin
               next_state = MBSRE_DROP;
            end else if (!isRead1(func) && !isRead3(func) && func != mbsre_pkg::FC_WRITE_COIL) begin
               next_exc = mbsre_pkg::EXC_ILL_FUNC;
            end else if (rxCnt < hdrLen + 4'd4) begin
               next_exc = mbsre_pkg::EXC_ILL_DATA;
            end else if (func == mbsre_pkg::FC_WRITE_COIL) begin
               if (start >= 16'(NACT)) begin
                  next_exc = mbsre_pkg::EXC_ILL_ADDR;
               end else if (value != mbsre_pkg::COIL_ON && value != mbsre_pkg::COIL_OFF) begin
                  next_exc = mbsre_pkg::EXC_ILL_DATA;
               end else if (serviceMode) begin
                  next_exc = mbsre_pkg::EXC_DEV_FAIL;
               end else begin
                  next_actionCoil[start[$clog2(NACT)-1:0]] = (value == mbsre_pkg::COIL_ON);
               end
            end else if (qty == 16'h0000) begin
               next_exc = mbsre_pkg::EXC_ILL_DATA;
            end else if (reach > (isRead1(func) ? 17'(NCOILS) : 17'(NREGS))) begin
               next_exc = mbsre_pkg::EXC_ILL_ADDR;
            end
            // length of function code plus data
            if (next_exc != '0) begin
               dataLen = 9'd2;
            end else if (func == mbsre_pkg::FC_WRITE_COIL) begin
               dataLen = 9'd5;
            end else if (isRead1(func)) begin
               dataLen = 9'd2 + 9'((qty + 16'd7) >> 3);
            end else begin
               dataLen = 9'd2 + 9'({qty[7:0], 1'b0});
            end
            next_txLen = 9'(hdrLen) - 9'd1 + dataLen + (tcpMode ? 9'd0 : 9'(mbsre_pkg::CRC_BYTES));
         end
         MBSRE_SEND: begin
            if (fifoInReady && txIdx == txLen - 9'd1) begin
               next_state = MBSRE_IDLE;
            end
         end
         MBSRE_DROP: begin
            next_state = MBSRE_IDLE;
         end
         default: begin
            next_state = MBSRE_IDLE;
         end
      endcase
   end

   // ==========================================================
   // response byte builder
   logic [8:0]  body;
   logic [15:0] bitBase;
   logic [15:0] regSel;
   logic [15:0] tcpLen;

   assign body    = txIdx - 9'(hdrLen) + 9'd1;
   assign bitBase = start + 16'({body - 9'd2, 3'd0});
   assign regSel  = start + {8'd0, body[8:1]} - 16'd1;
   assign tcpLen  = 16'(txLen) - 16'd6;
   assign regIndex = RW'(regSel);

   always_comb begin
      outB = '0;
      if (txIdx < 9'(hdrLen) - 9'd1) begin
         if (!tcpMode) begin
            outB = slaveId;
         end else if (txIdx == 9'd4) begin
            outB = tcpLen[15:8];
         end else if (txIdx == 9'd5) begin
            outB = tcpLen[7:0];
         end else begin
            outB = hdr[3'(txIdx)];
         end
      end else if (!tcpMode && txIdx >= txLen - 9'd2) begin
         outB = (txIdx == txLen - 9'd2) ? crc[7:0] : crc[15:8];
      end else if (body == 9'd0) begin
         outB = (exc != '0) ? (func | mbsre_pkg::EXC_FLAG) : func;
      end else if (exc != '0) begin
         outB = exc;
      end else if (func == mbsre_pkg::FC_WRITE_COIL) begin
         outB = pdu[2'(body - 9'd1)];
      end else if (body == 9'd1) begin
         outB = 8'(dataLenOf(func, qty));
      end else if (isRead1(func)) begin
         for (int b = 0; b < 8; b++) begin
            if (32'(bitBase) + b < reach && 32'(bitBase) + b < NCOILS) begin
               outB[b] = coilStatus[32'(bitBase) + b];
            end
         end
      end else begin
         // even register of a pair is the low half of the float
         if (body[0]) begin
            outB = regSel[0] ? regFloat[23:16] : regFloat[7:0];
         end else begin
            outB = regSel[0] ? regFloat[31:24] : regFloat[15:8];
         end
      end
   end

   function automatic logic [8:0] dataLenOf(input logic [7:0] f, input logic [15:0] q);
      dataLenOf = isRead1(f) ? 9'((q + 16'd7) >> 3) : 9'({q[7:0], 1'b0});
   endfunction

   assign fifoInValid = (state == MBSRE_SEND);
   assign fifoIn.data = outB;
   assign fifoIn.last = (txIdx == txLen - 9'd1);
   assign crcClear    = (state == MBSRE_EXEC);
   assign crcEn       = fifoInValid && fifoInReady;
   assign next_txIdx  = (state != MBSRE_SEND) ? '0 : (crcEn ? txIdx + 9'd1 : txIdx);

   mbsre_crc u_crc (
      .clock  (clock),
      .reset  (reset),
      .clear  (crcClear),
      .enable (crcEn && (tcpMode || txIdx < txLen - 9'd2)),
      .data   (outB),
      .crc    (crc)
   );

   mbsre_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
      .clock    (clock),
      .reset    (reset),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoIn),
      .outValid (txValid),
      .outReady (txReady),
      .outData  (txByte)
   );

   // ==========================================================
   // registers
   always_ff @(posedge clock) begin
      if (reset) begin
         state      <= MBSRE_IDLE;
         hdr        <= '{default: mbsre_pkg::RST_BYTE};
         pdu        <= '{default: mbsre_pkg::RST_BYTE};
         rxCnt      <= '0;
         func       <= mbsre_pkg::RST_BYTE;
         exc        <= mbsre_pkg::RST_BYTE;
         txIdx      <= '0;
         txLen      <= '0;
         actionCoil <= '0;
      end else begin
         state      <= next_state;
         hdr        <= next_hdr;
         pdu        <= next_pdu;
         rxCnt      <= next_rxCnt;
         func       <= next_func;
         exc        <= next_exc;
         txIdx      <= next_txIdx;
         txLen      <= next_txLen;
         actionCoil <= next_actionCoil;
      end
   end

   // ==========================================================
   // checks
   sequence s_force_exec;
      state == MBSRE_EXEC && next_state == MBSRE_SEND && func == mbsre_pkg::FC_WRITE_COIL && next_exc == '0;
   endsequence

   AST_NO_FORCE_IN_SERVICE: assert property (@(posedge clock) disable iff (reset)
      (state == MBSRE_EXEC && serviceMode) |=> $stable(actionCoil))
      else $error("coil changed in service mode");
   AST_FORCE_BEFORE_ECHO: assert property (@(posedge clock) disable iff (reset)
      s_force_exec |=> state == MBSRE_SEND
         && actionCoil[start[$clog2(NACT)-1:0]] == (value == mbsre_pkg::COIL_ON))
      else $error("force echo ordering broken");
   AST_DROP_FOREIGN_ID: assert property (@(posedge clock) disable iff (reset)
      (state == MBSRE_EXEC && !tcpMode && !idOk(hdr[0])) |=> state == MBSRE_DROP)
      else $error("foreign id answered");
   AST_DROP_BROADCAST: assert property (@(posedge clock) disable iff (reset)
      (state == MBSRE_EXEC && !tcpMode && hdr[0] == mbsre_pkg::ADDR_BROADCAST) |=> state != MBSRE_SEND)
      else $error("broadcast answered");
   AST_ILL_FUNC: assert property (@(posedge clock) disable iff (reset)
      (state == MBSRE_EXEC && next_state == MBSRE_SEND && func > mbsre_pkg::FC_WRITE_COIL)
      |=> exc == mbsre_pkg::EXC_ILL_FUNC)
      else $error("illegal function not flagged");
   AST_EXC_CODE: assert property (@(posedge clock) disable iff (reset)
      (fifoInValid && body == 9'd0 && txIdx < txLen && exc != '0) |-> outB[7])
      else $error("exception flag missing");
   AST_ZERO_QTY: assert property (@(posedge clock) disable iff (reset)
      (state == MBSRE_EXEC && next_state == MBSRE_SEND && (isRead1(func) || isRead3(func))
       && rxCnt >= hdrLen + 4'd4 && qty == 16'h0000) |=> exc == mbsre_pkg::EXC_ILL_DATA)
      else $error("zero quantity accepted");
   AST_SEND_BOUND: assert property (@(posedge clock) disable iff (reset)
      (state == MBSRE_SEND && fifoInReady && fifoIn.last) |=> state == MBSRE_IDLE)
      else $error("send did not end on last byte");
endmodule

// ===== verification/mbsre_master_model.sv
`timescale 1ns/1ns
// ==========================================================
// request master on the far side of the engine
module mbsre_master_model (
   input  wire logic                   clock,
   input  wire logic                   txValid,
   input  wire mbsre_pkg::mbsre_byte_t txByte,
   output logic                        txReady,
   output logic                        rxValid,
   output mbsre_pkg::mbsre_byte_t      rxByte,
   output logic                        rxCrcOk
);
   int slow;

   initial begin
      slow    = 0;
      txReady = 1'b0;
      rxValid = 1'b0;
      rxByte  = '0;
      rxCrcOk = 1'b0;
   end

   function automatic logic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction

   // serial: id, pdu, check low byte first; tcp: app header and no check field
   task automatic build(input logic tcp, input logic [7:0] id, input logic [15:0] txn, input logic [15:0] proto,
                        input logic [7:0] pdu[$], output logic [7:0] f[$]);
      logic [15:0] len;
      logic [15:0] c;
      len = 16'(pdu.size() + 1);
      if (tcp) begin
         f = {txn[15:8], txn[7:0], proto[15:8], proto[7:0], len[15:8], len[7:0], id};
         f = {f, pdu};
      end else begin
         f = {id, pdu};
         c = crc16(f);
         f = {f, c[7:0], c[15:8]};
      end
   endtask

   task automatic send(input logic [7:0] f[$], input logic crcGood);
      rxCrcOk = crcGood;
      foreach (f[i]) begin
         @(negedge clock);
         rxValid     = 1'b1;
         rxByte.data = f[i];
         rxByte.last = (i == f.size() - 1);
      end
      @(negedge clock);
      rxValid     = 1'b0;
      rxByte.data = ~rxByte.data;  // idle line must not look like the last byte
      rxByte.last = 1'b0;
      @(negedge clock);
   endtask

   // slow mode stalls long enough to fill the reply buffer, then takes one byte in three
   task automatic recv(output logic [7:0] f[$], output logic timedOut);
      int n;
      n        = 0;
      f        = {};
      timedOut = 1'b1;
      while (n < 600) begin
         @(negedge clock);
         txReady = (slow == 0) || (n > 40 && n % 3 == 0);
         n++;
         if (txValid && txReady) begin
            f.push_back(txByte.data);
            if (txByte.last) begin
               timedOut = 1'b0;
               n        = 600;
            end
         end
      end
      @(negedge clock);
      txReady = 1'b0;
   endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ns
module tb;
   localparam int NCOILS = 18;
   localparam int NREGS  = 117;
   localparam int NACT   = 18;

   logic                       clock;
   logic                       reset;
   logic                       tcpMode;
   logic [7:0]                 slaveId;
   logic [1:0]                 tcpConnCount;
   logic                       serviceMode;
   logic                       rxValid;
   mbsre_pkg::mbsre_byte_t     rxByte;
   logic                       rxCrcOk;
   logic [NCOILS-1:0]          coilStatus;
   logic [$clog2(NREGS)-1:0]   regIndex;
   logic [31:0]                regFloat;
   logic [NACT-1:0]            actionCoil;
   logic                       txValid;
   logic                       txReady;
   mbsre_pkg::mbsre_byte_t     txByte;
   logic                       acceptConn;
   logic [7:0]                 unitId;
   logic [15:0]                txn;
   int                         errors;
   int                         compares;

   // each pair gets its own pattern; the top byte tells the halves apart
   assign regFloat = {8'hC3, 2'b00, regIndex[6:1], 8'h5A, 2'b00, regIndex[6:1]};

   mbsre_engine #(.NCOILS(NCOILS), .NREGS(NREGS), .NACT(NACT), .DEPTH(8)) i_mbsre_engine (
      .clock(clock), .reset(reset), .tcpMode(tcpMode), .slaveId(slaveId), .tcpConnCount(tcpConnCount),
      .serviceMode(serviceMode), .rxValid(rxValid), .rxByte(rxByte), .rxCrcOk(rxCrcOk),
      .coilStatus(coilStatus), .regIndex(regIndex), .regFloat(regFloat), .actionCoil(actionCoil),
      .txValid(txValid), .txReady(txReady), .txByte(txByte), .acceptConn(acceptConn));

   mbsre_master_model master (
      .clock(clock), .txValid(txValid), .txByte(txByte), .txReady(txReady),
      .rxValid(rxValid), .rxByte(rxByte), .rxCrcOk(rxCrcOk));

   // ==========================================================
   // helpers
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [15:0] regVal(input int r);
      logic [31:0] f;
      f = {8'hC3, 2'b00, 6'(r / 2), 8'h5A, 2'b00, 6'(r / 2)};
      return (r % 2 == 0) ? f[15:0] : f[31:16];
   endfunction

   task automatic transact(input logic [7:0] pdu[$], input logic [7:0] exp[$]);
      logic [7:0] req[$];
      logic [7:0] want[$];
      logic [7:0] got[$];
      logic       to;
      master.build(tcpMode, tcpMode ? unitId : slaveId, txn, 16'h0000, pdu, req);
      master.build(tcpMode, tcpMode ? unitId : slaveId, txn, 16'h0000, exp, want);
      master.send(req, 1'b1);
      master.recv(got, to);
      check8("reply timeout", 8'h00, {7'h00, to});
      check8("reply length", 8'(want.size()), 8'(got.size()));
      foreach (want[i]) begin
         check8("reply byte", want[i], (i < got.size()) ? got[i] : 8'hxx);
      end
      check8("buffer drained", 8'h00, {7'h00, txValid});
   endtask

   task automatic silent(input logic [7:0] id, input logic [15:0] proto, input logic crcGood);
      logic [7:0] req[$];
      logic       seen;
      seen = 1'b0;
      master.build(tcpMode, id, txn, proto, {8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, req);
      master.send(req, crcGood);
      repeat (60) begin
         @(negedge clock);
         seen = seen | txValid;
      end
      check8("dropped frame", 8'h00, {7'h00, seen});
   endtask

   // ==========================================================
   // scenarios
   task automatic test_registers();
      logic [7:0]  exp[$];
      logic [15:0] v;
      int          st [3] = '{9, 9, 115};
      for (int k = 0; k < 3; k++) begin
         exp = {8'(3 + k % 2), 8'h00};
         exp[1] = (k == 2) ? 8'h04 : 8'h08;
         for (int r = st[k]; r < st[k] + exp[1] / 2; r++) begin
            v   = regVal(r);
            exp = {exp, v[15:8], v[7:0]};
         end
         master.slow = k % 2;
         transact({exp[0], 8'h00, 8'(st[k]), 8'h00, exp[1] / 2}, exp);
      end
      master.slow = 0;
   endtask

   task automatic test_coils();
      logic [7:0] exp[$];
      logic [7:0] b;
      int         st [3] = '{2, 2, 0};
      int         qt [3] = '{13, 13, 18};
      for (int k = 0; k < 3; k++) begin
         exp = {8'(1 + k % 2), 8'((qt[k] + 7) / 8)};
         for (int i = 0; i < qt[k]; i += 8) begin
            b = 8'h00;
            for (int j = 0; j < 8 && i + j < qt[k]; j++) begin
               b[j] = coilStatus[st[k] + i + j];
            end
            exp.push_back(b);
         end
         transact({exp[0], 8'h00, 8'(st[k]), 8'h00, 8'(qt[k])}, exp);
      end
   endtask

   task automatic test_force();
      logic [7:0]  pdu[$];
      logic [15:0] val [4] = '{16'hFF00, 16'h0000, 16'h1234, 16'hFF00};
      logic [7:0]  exc [4] = '{8'h00, 8'h00, 8'h03, 8'h04};
      for (int k = 0; k < 4; k++) begin
         @(negedge clock);
         serviceMode = (k == 3);
         pdu = {8'h05, 8'h00, 8'h05, val[k][15:8], val[k][7:0]};
         if (exc[k] == 8'h00) begin
            transact(pdu, pdu);
         end else begin
            transact(pdu, {8'h85, exc[k]});
         end
         check8("coil 5 state", {7'h00, k == 0}, {7'h00, actionCoil[5]});
      end
      serviceMode = 1'b0;
   endtask

   task automatic test_exceptions();
      logic [7:0] bad [5] = '{8'h00, 8'h06, 8'h07, 8'h2B, 8'h7F};
      foreach (bad[k]) begin
         transact({bad[k], 8'h00, 8'h00, 8'h00, 8'h01}, {bad[k] | 8'h80, 8'h01});
      end
      transact({8'h01, 8'h00, 8'h11, 8'h00, 8'h02}, {8'h81, 8'h02});
      transact({8'h04, 8'h00, 8'h73, 8'h00, 8'h03}, {8'h84, 8'h02});
      transact({8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h83, 8'h03});
      transact({8'h05, 8'h00, 8'(NACT), 8'hFF, 8'h00}, {8'h85, 8'h02});
   endtask

   task automatic test_address();
      logic [7:0]  ids [4] = '{8'h12, 8'h00, 8'h80, 8'hF7};
      logic [15:0] v;
      v = regVal(0);
      foreach (ids[k]) begin
         silent(ids[k], 16'h0000, 1'b1);
      end
      silent(slaveId, 16'h0000, 1'b0);
      for (int k = 0; k < 2; k++) begin
         @(negedge clock);
         slaveId = k ? 8'h7F : 8'h01;
         transact({8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h03, 8'h02, v[15:8], v[7:0]});
      end
      slaveId = 8'h11;
   endtask

   task automatic test_tcp();
      logic [15:0] v;
      logic [15:0] w;
      v = regVal(0);
      w = regVal(1);
      @(negedge clock);
      tcpMode = 1'b1;
      unitId  = 8'hA7;
      txn     = 16'hBEEF;
      transact({8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, {8'h04, 8'h04, v[15:8], v[7:0], w[15:8], w[7:0]});
      unitId = 8'h00;
      txn    = 16'h0001;
      transact({8'h02, 8'h00, 8'h00, 8'h00, 8'h03}, {8'h02, 8'h01, 8'(coilStatus[2:0])});
      silent(unitId, 16'h0001, 1'b1);
      for (int k = 0; k < 4; k++) begin
         @(negedge clock);
         tcpConnCount = 2'(k);
         #1;
         check8("accept connection", {7'h00, k < 3}, {7'h00, acceptConn});
      end
      tcpMode = 1'b0;
   endtask

   // ==========================================================
   // run control
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial begin
      errors       = 0;
      compares     = 0;
      reset        = 1'b1;
      tcpMode      = 1'b0;
      slaveId      = 8'h11;
      tcpConnCount = 2'b00;
      serviceMode  = 1'b0;
      coilStatus   = 18'h2_C3B5;
      unitId       = 8'h00;
      txn          = 16'h0000;
      repeat (10) @(negedge clock);
      reset = 1'b0;
      test_registers();
      test_coils();
      test_force();
      test_exceptions();
      test_address();
      test_tcp();
      complete_run();
   end

   // about thirty short transfers; this leaves ample margin
   initial begin
      #(20 * 60000);
      errors++;
      complete_run();
   end
endmodule
